//--- mfre_regs.svh
// constants of the multi-wire fast read engine: opcodes, phase lengths, masks
`ifndef MFRE_REGS_SVH
`define MFRE_REGS_SVH
`define MFRE_OP_QUAD_OUT 8'h6b
`define MFRE_OP_DUAL_IO 8'hbb
`define MFRE_OP_QUAD_IO 8'heb
`define MFRE_OP_RESET 8'h99
`define MFRE_OP_MODE_RESET 8'hff
`define MFRE_CONT_NIBBLE 4'ha
`define MFRE_LANE_1 3'h1
`define MFRE_LANE_2 3'h2
`define MFRE_LANE_4 3'h4
`define MFRE_OPC_CLK_SPI 5'h08
`define MFRE_OPC_CLK_QPI 5'h02
`define MFRE_ADDR_CLK_1 5'h18
`define MFRE_ADDR_CLK_2 5'h0c
`define MFRE_ADDR_CLK_4 5'h06
`define MFRE_MODE_CLK_2 5'h04
`define MFRE_MODE_CLK_4 5'h02
`define MFRE_DUMMY_QOUT 5'h08
`define MFRE_DUMMY_QIO_SPI 5'h04
`define MFRE_QPI_DUMMY_P0 5'h04
`define MFRE_QPI_DUMMY_P1 5'h06
`define MFRE_QPI_DUMMY_P2 5'h08
`define MFRE_QPI_DUMMY_P3 5'h08
`define MFRE_QPI_MODE_SHARE 5'h04
`define MFRE_READ_PARAM_RST 2'h0
`define MFRE_WRAP_MASK_8 6'h07
`define MFRE_WRAP_MASK_16 6'h0f
`define MFRE_WRAP_MASK_32 6'h1f
`define MFRE_WRAP_MASK_64 6'h3f
`define MFRE_BYTE_BITS 4'h8
`define MFRE_PIN_RST 6'h20
`define MFRE_FIFO_DEPTH 8
`define MFRE_DATA_W 8
`define MFRE_ADDR_W 24
`endif

//--- mfre_pkg.sv
// types shared by the fast read engine
package mfre_pkg;
  typedef enum logic [2:0] {MFRE_IDLE, MFRE_OPC, MFRE_ADDR, MFRE_MODE, MFRE_DUMMY, MFRE_DATA,
    MFRE_SKIP} mfre_phase_e;
  typedef enum logic [1:0] {MFRE_CMD_QOUT, MFRE_CMD_DIO, MFRE_CMD_QIO} mfre_cmd_e;
  typedef struct packed {
    logic [5:0] pinS1;
    logic [5:0] pinS2;
    logic sclkS3;
    mfre_phase_e phase;
    mfre_cmd_e cmd;
    logic [2:0] laneW;
    logic [4:0] cnt;
    logic [4:0] len;
    logic [23:0] shift;
    logic [23:0] fetchAddr;
    logic fetchOn;
    logic reqValid;
    logic outstanding;
    logic dropNext;
    logic [7:0] outByte;
    logic [3:0] bitsLeft;
    logic [3:0] ioOut;
    logic [3:0] ioOeN;
    logic contOn;
    mfre_cmd_e contCmd;
    logic contFrame;
    logic allOnes;
    logic [1:0] readParam;
    logic wrapOn;
    logic [1:0] wrapLen;
    logic wrapThis;
    logic frameActive;
  } mfre_state_s;
endpackage

//--- mfre_fifo.sv
// small synchronous fifo between the memory read port and the serial shifter
`timescale 1ns/1ps
module mfre_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic flush, // drop all contents
  input wire logic inValid, // write data valid
  input wire logic [WIDTH-1:0] inData, // write data
  output logic inReady, // room for one more word
  output logic outValid, // read data valid
  output logic [WIDTH-1:0] outData, // read data
  input wire logic outReady // consumer takes the head word
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic notFull;
    logic notEmpty;
  } mfre_fifo_s;
  mfre_fifo_s st_q;
  mfre_fifo_s st_d;
  logic push;
  logic pop;

  assign push = inValid && st_q.notFull;
  assign pop = outReady && st_q.notEmpty;
  assign inReady = st_q.notFull;
  assign outValid = st_q.notEmpty;
  assign outData = st_q.mem[st_q.rp];

  always_comb begin
    st_d = st_q;
    if (flush) begin
      st_d.wp = '0;
      st_d.rp = '0;
      st_d.count = '0;
    end else begin
      if (push) begin
        st_d.mem[st_q.wp] = inData;
        st_d.wp = st_q.wp + 1'b1;
      end
      if (pop) begin
        st_d.rp = st_q.rp + 1'b1;
      end
      if (push && !pop) begin
        st_d.count = st_q.count + 1'b1;
      end else if (pop && !push) begin
        st_d.count = st_q.count - 1'b1;
      end
    end
    // flags registered so the ready port leaves a flop
    st_d.notFull = st_d.count != (AW+1)'(DEPTH);
    st_d.notEmpty = st_d.count != '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.notFull <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

//--- mfre_engine.sv
// device-side read front end for quad-output, dual i/o and quad i/o fast reads
//
// Notes on behaviour
// - quad-output read returns four bits per clock
// - quad-output read needs quad read permit set
// - eight dummy clocks follow quad-output address
// - dual i/o moves address, mode, data two-wide
// - capture mode byte, only upper nibble matters
// - dual i/o nibble A skips next opcode
// - quad i/o nibble A skips next opcode
// - other nibble restores opcode-first decoding
// - mode reset sequence clears continuous read
// - quad i/o read needs quad read permit
// - wrap setting governs later single-wire quad i/o reads
// - wrap inside 8/16/32/64 byte page section
// - four-wire dummy count 4/6/8, default 4
// - four-wire continuous read, mode counts as dummy
// - no wrap in four-wire command mode
// - data shifts on falling, inputs on rising
// - address steps by one per byte
`timescale 1ns/1ps
`include "mfre_regs.svh"
module mfre_engine (
  input wire logic clk, // 200 MHz core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic csN, // chip select pin, active low
  input wire logic sclk, // serial clock pin
  input wire logic [3:0] ioIn, // io3..io0 pin levels
  output logic [3:0] ioOut, // io3..io0 drive values
  output logic [3:0] ioOeN, // io3..io0 output enables, low drives
  input wire logic quadReadPermit, // permit bit of the second status register
  input wire logic fourWireCmdMode, // four-wire command mode active
  input wire logic wrapSetWr, // pulse: load wrap setting
  input wire logic wrapSetEn, // wrap enable to load
  input wire logic [1:0] wrapSetLen, // 0:8 1:16 2:32 3:64 byte section
  input wire logic readParamWr, // pulse: load read parameter bits
  input wire logic [1:0] readParamIn, // read parameter bits for dummy count
  output logic memReqValid, // byte fetch request valid
  output logic [23:0] memReqAddr, // byte fetch address
  input wire logic memReqReady, // memory takes the request
  input wire logic memRdValid, // fetched byte valid
  input wire logic [7:0] memRdData, // fetched byte
  output logic memRdReady, // fifo has room for the byte
  output logic contModeActive, // continuous read armed
  output logic frameActive // select seen low
);
  mfre_pkg::mfre_state_s st_q;
  mfre_pkg::mfre_state_s st_d;
  logic csHigh;
  logic rise;
  logic fall;
  logic [3:0] ioS;
  logic fifoFlush;
  logic fifoPop;
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic [7:0] curByte;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [23:0] shiftIn(input logic [23:0] s, input logic [3:0] io,
      input logic [2:0] w);
    logic [23:0] r;
    r = {s[19:0], io};
    if (w == `MFRE_LANE_1) begin
      r = {s[22:0], io[0]};
    end else if (w == `MFRE_LANE_2) begin
      r = {s[21:0], io[1:0]};
    end
    return r;
  endfunction

  function automatic logic [5:0] wrapMask(input logic [1:0] len);
    logic [5:0] m;
    unique case (len)
      2'h0: m = `MFRE_WRAP_MASK_8;
      2'h1: m = `MFRE_WRAP_MASK_16;
      2'h2: m = `MFRE_WRAP_MASK_32;
      2'h3: m = `MFRE_WRAP_MASK_64;
    endcase
    return m;
  endfunction

  function automatic logic [23:0] nextAddr(input logic [23:0] a, input logic wrap,
      input logic [1:0] len);
    logic [23:0] m;
    logic [23:0] inc;
    m = {18'h0, wrapMask(len)};
    inc = a + 24'h1;
    if (wrap) begin
      inc = (a & ~m) | (inc & m);
    end
    return inc;
  endfunction

  // clocks left between mode byte and data
  function automatic logic [4:0] dummyLen(input mfre_pkg::mfre_cmd_e c, input logic four_wire_command_mode,
      input logic [1:0] p);
    logic [4:0] d;
    d = 5'h00;
    if (c == mfre_pkg::MFRE_CMD_QIO) begin
      if (four_wire_command_mode) begin
        // mode clocks are part of the count, so the default gives data at once
        unique case (p)
          2'h0: d = `MFRE_QPI_DUMMY_P0 - `MFRE_QPI_MODE_SHARE;
          2'h1: d = `MFRE_QPI_DUMMY_P1 - `MFRE_QPI_MODE_SHARE;
          2'h2: d = `MFRE_QPI_DUMMY_P2 - `MFRE_QPI_MODE_SHARE;
          2'h3: d = `MFRE_QPI_DUMMY_P3 - `MFRE_QPI_MODE_SHARE;
        endcase
      end else begin
        d = `MFRE_DUMMY_QIO_SPI;
      end
    end
    return d;
  endfunction

  function automatic logic [4:0] addrLen(input mfre_pkg::mfre_cmd_e c);
    logic [4:0] l;
    unique case (c)
      mfre_pkg::MFRE_CMD_QOUT: l = `MFRE_ADDR_CLK_1;
      mfre_pkg::MFRE_CMD_DIO: l = `MFRE_ADDR_CLK_2;
      mfre_pkg::MFRE_CMD_QIO: l = `MFRE_ADDR_CLK_4;
      default: l = `MFRE_ADDR_CLK_1;
    endcase
    return l;
  endfunction

  function automatic logic [2:0] addrLane(input mfre_pkg::mfre_cmd_e c);
    logic [2:0] w;
    unique case (c)
      mfre_pkg::MFRE_CMD_DIO: w = `MFRE_LANE_2;
      mfre_pkg::MFRE_CMD_QIO: w = `MFRE_LANE_4;
      default: w = `MFRE_LANE_1;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin view: two flops per pin, third stage only on the clock for edges

  assign csHigh = st_q.pinS2[5];
  assign rise = st_q.pinS2[4] && !st_q.sclkS3;
  assign fall = !st_q.pinS2[4] && st_q.sclkS3;
  assign ioS = st_q.pinS2[3:0];
  assign curByte = (st_q.bitsLeft == 4'h0) ? fifoOutData : st_q.outByte;
  assign fifoInValid = memRdValid && !st_q.dropNext;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    fifoFlush = 1'b0;
    fifoPop = 1'b0;
    st_d.pinS1 = {csN, sclk, ioIn};
    st_d.pinS2 = st_q.pinS1;
    st_d.sclkS3 = st_q.pinS2[4];

    if (wrapSetWr) begin
      st_d.wrapOn = wrapSetEn;
      st_d.wrapLen = wrapSetLen;
    end
    if (readParamWr) begin
      st_d.readParam = readParamIn;
    end

    // fetch side: one request in flight keeps the fifo from overflowing
    if (memRdValid && fifoInReady) begin
      st_d.outstanding = 1'b0;
      st_d.dropNext = 1'b0;
    end
    if (st_q.reqValid && memReqReady) begin
      st_d.reqValid = 1'b0;
      st_d.outstanding = 1'b1;
      st_d.fetchAddr = nextAddr(st_q.fetchAddr, st_q.wrapThis, st_q.wrapLen);
    end
    if (st_q.fetchOn && !csHigh && !st_q.reqValid && !st_q.outstanding && fifoInReady) begin
      st_d.reqValid = 1'b1;
    end

    if (csHigh) begin
      // a frame cut off inside a skipped-opcode address of all ones undoes the mode
      if (st_q.phase == mfre_pkg::MFRE_ADDR && st_q.contFrame && st_q.allOnes &&
          st_q.cnt != 5'h00) begin
        st_d.contOn = 1'b0;
      end
      if (st_q.outstanding || st_q.reqValid) begin
        st_d.dropNext = 1'b1;
      end
      st_d.phase = mfre_pkg::MFRE_IDLE;
      st_d.ioOeN = 4'hf;
      st_d.frameActive = 1'b0;
      st_d.fetchOn = 1'b0;
      st_d.contFrame = 1'b0;
      fifoFlush = 1'b1;
    end else if (st_q.phase == mfre_pkg::MFRE_IDLE) begin
      st_d.frameActive = 1'b1;
      st_d.cnt = 5'h00;
      st_d.allOnes = 1'b1;
      st_d.bitsLeft = 4'h0;
      if (st_q.contOn) begin
        st_d.phase = mfre_pkg::MFRE_ADDR;
        st_d.cmd = st_q.contCmd;
        st_d.contFrame = 1'b1;
        st_d.laneW = addrLane(st_q.contCmd);
        st_d.len = addrLen(st_q.contCmd);
      end else begin
        st_d.phase = mfre_pkg::MFRE_OPC;
        st_d.laneW = fourWireCmdMode ? `MFRE_LANE_4 : `MFRE_LANE_1;
        st_d.len = fourWireCmdMode ? `MFRE_OPC_CLK_QPI : `MFRE_OPC_CLK_SPI;
      end
    end else if (rise && st_q.phase != mfre_pkg::MFRE_DATA &&
        st_q.phase != mfre_pkg::MFRE_SKIP) begin
      st_d.shift = shiftIn(st_q.shift, ioS, st_q.laneW);
      st_d.cnt = st_q.cnt + 5'h01;
      if (!ioS[0]) begin
        st_d.allOnes = 1'b0;
      end
      if (st_q.cnt + 5'h01 == st_q.len) begin
        st_d.cnt = 5'h00;
        unique case (st_q.phase)
          mfre_pkg::MFRE_OPC: begin
            st_d.phase = mfre_pkg::MFRE_ADDR;
            if (st_d.shift[7:0] == `MFRE_OP_QUAD_OUT && quadReadPermit &&
                !fourWireCmdMode) begin
              st_d.cmd = mfre_pkg::MFRE_CMD_QOUT;
            end else if (st_d.shift[7:0] == `MFRE_OP_DUAL_IO && !fourWireCmdMode) begin
              st_d.cmd = mfre_pkg::MFRE_CMD_DIO;
            end else if (st_d.shift[7:0] == `MFRE_OP_QUAD_IO && quadReadPermit) begin
              st_d.cmd = mfre_pkg::MFRE_CMD_QIO;
            end else begin
              st_d.phase = mfre_pkg::MFRE_SKIP;
              if (st_d.shift[7:0] == `MFRE_OP_RESET) begin
                st_d.readParam = `MFRE_READ_PARAM_RST;
                st_d.contOn = 1'b0;
              end
              if (st_d.shift[7:0] == `MFRE_OP_MODE_RESET) begin
                st_d.contOn = 1'b0;
              end
            end
            st_d.laneW = addrLane(st_d.cmd);
            st_d.len = addrLen(st_d.cmd);
          end
          mfre_pkg::MFRE_ADDR: begin
            // prefetch starts as soon as the address is whole
            st_d.fetchAddr = st_d.shift;
            st_d.fetchOn = 1'b1;
            st_d.wrapThis = st_q.wrapOn && !fourWireCmdMode &&
              st_q.cmd == mfre_pkg::MFRE_CMD_QIO;
            st_d.dropNext = st_d.outstanding || st_d.reqValid;
            fifoFlush = 1'b1;
            if (st_q.cmd == mfre_pkg::MFRE_CMD_QOUT) begin
              st_d.phase = mfre_pkg::MFRE_DUMMY;
              st_d.len = `MFRE_DUMMY_QOUT;
            end else begin
              st_d.phase = mfre_pkg::MFRE_MODE;
              st_d.len = (st_q.cmd == mfre_pkg::MFRE_CMD_DIO) ? `MFRE_MODE_CLK_2 :
                `MFRE_MODE_CLK_4;
            end
          end
          mfre_pkg::MFRE_MODE: begin
            // low nibble is never looked at
            st_d.contOn = st_d.shift[7:4] == `MFRE_CONT_NIBBLE;
            st_d.contCmd = st_q.cmd;
            st_d.len = dummyLen(st_q.cmd, fourWireCmdMode, st_q.readParam);
            if (st_d.len == 5'h00) begin
              st_d.phase = mfre_pkg::MFRE_DATA;
            end else begin
              st_d.phase = mfre_pkg::MFRE_DUMMY;
            end
          end
          default: begin
            st_d.phase = mfre_pkg::MFRE_DATA;
          end
        endcase
        if (st_d.phase == mfre_pkg::MFRE_DATA) begin
          st_d.laneW = (st_q.cmd == mfre_pkg::MFRE_CMD_DIO) ? `MFRE_LANE_2 : `MFRE_LANE_4;
        end
      end
    end else if (fall && st_q.phase == mfre_pkg::MFRE_DATA) begin
      // pins stay released through address, mode and dummy clocks
      // the fetch must beat the first falling edge; an empty fifo sends stale bits
      if (st_q.bitsLeft == 4'h0) begin
        fifoPop = fifoOutValid;
        st_d.bitsLeft = `MFRE_BYTE_BITS - {1'b0, st_q.laneW};
      end else begin
        st_d.bitsLeft = st_q.bitsLeft - {1'b0, st_q.laneW};
      end
      if (st_q.laneW == `MFRE_LANE_2) begin
        st_d.ioOut = {2'h0, curByte[7:6]};
        st_d.ioOeN = 4'hc;
        st_d.outByte = {curByte[5:0], 2'h0};
      end else begin
        st_d.ioOut = curByte[7:4];
        st_d.ioOeN = 4'h0;
        st_d.outByte = {curByte[3:0], 4'h0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.pinS1 <= `MFRE_PIN_RST;
      st_q.pinS2 <= `MFRE_PIN_RST;
      st_q.ioOeN <= 4'hf;
      st_q.readParam <= `MFRE_READ_PARAM_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data buffer and outputs

  mfre_fifo #(
    .WIDTH(`MFRE_DATA_W),
    .DEPTH(`MFRE_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(fifoFlush),
    .inValid(fifoInValid),
    .inData(memRdData),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoPop)
  );

  assign ioOut = st_q.ioOut;
  assign ioOeN = st_q.ioOeN;
  assign memReqValid = st_q.reqValid;
  assign memReqAddr = st_q.fetchAddr;
  assign memRdReady = fifoInReady;
  assign contModeActive = st_q.contOn;
  assign frameActive = st_q.frameActive;
endmodule

//--- mfre_engine_sva.sv
// port checker for the multi-wire fast read engine
`timescale 1ns/1ps
module mfre_engine_sva (
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic csN, // select pin
  input wire logic sclk, // serial clock pin
  input wire logic [3:0] ioIn, // pin levels
  input wire logic [3:0] ioOut, // drive values
  input wire logic [3:0] ioOeN, // enables, low drives
  input wire logic quadReadPermit, // permit bit
  input wire logic fourWireCmdMode, // four-wire mode
  input wire logic wrapSetWr, // wrap load
  input wire logic wrapSetEn, // wrap enable
  input wire logic [1:0] wrapSetLen, // wrap size
  input wire logic readParamWr, // param load
  input wire logic [1:0] readParamIn, // param bits
  input wire logic memReqValid, // fetch valid
  input wire logic [23:0] memReqAddr, // fetch address
  input wire logic memReqReady, // fetch taken
  input wire logic memRdValid, // byte valid
  input wire logic [7:0] memRdData, // byte
  input wire logic memRdReady, // fifo room
  input wire logic contModeActive, // continuous armed
  input wire logic frameActive // select seen low
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> ioOeN == 4'hf && !memReqValid
    && !contModeActive && !frameActive) else $error("outputs not idle after reset");
  a_quiet_deselect: assert property (!frameActive && !$past(frameActive) |-> ioOeN == 4'hf)
    else $error("pins driven outside a frame");
  a_req_hold: assert property (memReqValid && !memReqReady |=>
    memReqValid && $stable(memReqAddr)) else $error("fetch request dropped or moved");
  a_one_flight: assert property (memReqValid && memReqReady |=> !memReqValid)
    else $error("second fetch without a gap");
  a_req_in_frame: assert property ($rose(memReqValid) |-> frameActive)
    else $error("fetch outside a frame");
  a_lane_groups: assert property (ioOeN == 4'hf || ioOeN == 4'h0 || ioOeN == 4'hc)
    else $error("pins driven in an odd group");
  a_no_dual_4w: assert property (fourWireCmdMode |-> ioOeN != 4'hc)
    else $error("two-wire drive in four-wire mode");
  a_shift_low: assert property (!ioOeN[0] && !$past(ioOeN[0]) && $changed(ioOut) |->
    !sclk && !$past(sclk) && !$past(sclk, 2)) else $error("data moved while clock high");
  a_drive_after_fall: assert property ($fell(ioOeN[0]) |-> !sclk && !$past(sclk, 2))
    else $error("drive began while clock high");
endmodule
bind mfre_engine mfre_engine_sva u_sva (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk),
  .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN), .quadReadPermit(quadReadPermit),
  .fourWireCmdMode(fourWireCmdMode), .wrapSetWr(wrapSetWr), .wrapSetEn(wrapSetEn),
  .wrapSetLen(wrapSetLen), .readParamWr(readParamWr), .readParamIn(readParamIn),
  .memReqValid(memReqValid), .memReqAddr(memReqAddr), .memReqReady(memReqReady),
  .memRdValid(memRdValid), .memRdData(memRdData), .memRdReady(memRdReady),
  .contModeActive(contModeActive), .frameActive(frameActive));

//--- mfre_host_model.sv
// serial host controller model: drives select and clock, resolves the io pins
`timescale 1ns/1ps
module mfre_host_model (
  input wire logic clk, // core clock
  output logic csN, // select, active low
  output logic sclk, // serial clock, idle low
  output logic [3:0] ioLine, // resolved pin levels
  input wire logic [3:0] ioOut, // device drive values
  input wire logic [3:0] ioOeN // device enables, low drives
);
  logic [3:0] hostOe;
  logic [3:0] hostDrv;
  logic [3:0] hostLast;
  // a released line shows the inverse of the last host level so stale bits never match
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ioLine[i] = !ioOeN[i] ? ioOut[i] : hostOe[i] ? hostDrv[i] : ~hostLast[i];
    end
  end
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    hostOe = 4'h0;
    hostDrv = 4'h0;
    hostLast = 4'h0;
  end
  // six core clocks per half period, above the device minimum of four
  task automatic half();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic start();
    csN = 1'b0;
    half();
  endtask
  task automatic stop();
    hostOe = 4'h0;
    half();
    csN = 1'b1;
    repeat (4) half();
  endtask
  // n clocks of lanes bits each, msb first; drive low leaves the pins to the device
  task automatic clocks(input int n, input int lanes, input logic drive,
      input logic [31:0] val, output logic [31:0] got);
    logic [3:0] mask;
    mask = 4'((1 << lanes) - 1);
    got = 32'h0;
    for (int i = 0; i < n; i++) begin
      hostOe = drive ? mask : 4'h0;
      hostDrv = 4'(val >> ((n - 1 - i) * lanes)) & mask;
      if (drive) hostLast = hostDrv;
      half();
      sclk = 1'b1;
      got = (got << lanes) | 32'(ioLine & mask);
      half();
      // release only once the device has taken the last rising edge
      if (drive && i == n - 1) hostOe = 4'h0;
      sclk = 1'b0;
    end
  endtask
endmodule

//--- test_multi_io_fast_read_engine.sv
// self-checking bench for the multi-wire fast read engine
`timescale 1ns/1ps
`include "mfre_regs.svh"
module test_multi_io_fast_read_engine;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic csN, sclk, memReqValid, memRdReady, contModeActive, frameActive;
  logic [3:0] ioIn, ioOut, ioOeN;
  logic quadReadPermit = 1'b1;
  logic fourWireCmdMode = 1'b0;
  logic wrapSetWr = 1'b0;
  logic wrapSetEn = 1'b0;
  logic [1:0] wrapSetLen = 2'h0;
  logic readParamWr = 1'b0;
  logic [1:0] readParamIn = 2'h0;
  logic [23:0] memReqAddr;
  logic memReqReady = 1'b0;
  logic memRdValid = 1'b0;
  logic [7:0] memRdData = 8'h00;
  logic drove = 1'b0;
  logic sawFull = 1'b0;
  logic reqTaken, rdTaken;
  logic [23:0] reqA;
  logic [3:0] stallCnt = 4'h0;
  logic [31:0] got;
  int miscompares = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  mfre_engine dut (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut),
    .ioOeN(ioOeN), .quadReadPermit(quadReadPermit), .fourWireCmdMode(fourWireCmdMode),
    .wrapSetWr(wrapSetWr), .wrapSetEn(wrapSetEn), .wrapSetLen(wrapSetLen),
    .readParamWr(readParamWr), .readParamIn(readParamIn), .memReqValid(memReqValid),
    .memReqAddr(memReqAddr), .memReqReady(memReqReady), .memRdValid(memRdValid),
    .memRdData(memRdData), .memRdReady(memRdReady), .contModeActive(contModeActive),
    .frameActive(frameActive));
  mfre_host_model host (.clk(clk), .csN(csN), .sclk(sclk), .ioLine(ioIn), .ioOut(ioOut),
    .ioOeN(ioOeN));
  ////////////////////////////////////////////////////////////////////////////////////////////
  // memory stand-in: byte equals low address byte, stalls the request every other pair
  always @(posedge clk) begin
    reqTaken = memReqValid && memReqReady;
    rdTaken = memRdValid && memRdReady;
    reqA = memReqAddr;
    if (memRdReady === 1'b0) sawFull = 1'b1;
    if (ioOeN !== 4'hf) drove = 1'b1;
    #1;
    stallCnt = stallCnt + 4'h1;
    if (rdTaken) memRdValid = 1'b0;
    if (reqTaken) begin
      memRdValid = 1'b1;
      memRdData = reqA[7:0];
    end
    memReqReady = !memRdValid && !reqTaken && stallCnt[1];
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] exp4(input logic [23:0] a);
    return {a[7:0], 8'(a + 24'h1), 8'(a + 24'h2), 8'(a + 24'h3)};
  endfunction
  // opClk zero skips the opcode; mode byte follows the address when aw is above one
  task automatic xfer(input logic [7:0] op, input int opClk, input int aw, input logic [23:0] a,
      input logic [7:0] mode, input int dummy, input int dw, output logic [31:0] data);
    logic [31:0] d;
    host.start();
    if (opClk > 0) host.clocks(opClk, 8 / opClk, 1'b1, 32'(op), d);
    host.clocks(24 / aw, aw, 1'b1, 32'(a), d);
    if (aw > 1) host.clocks(8 / aw, aw, 1'b1, 32'(mode), d);
    if (dummy > 0) host.clocks(dummy, 4, 1'b0, 32'h0, d);
    host.clocks(32 / dw, dw, 1'b0, 32'h0, data);
    host.stop();
  endtask
  task automatic strobe_cfg(input logic wr, input logic [1:0] val);
    @(posedge clk);
    #1;
    {wrapSetEn, wrapSetLen, readParamIn} = {wr, val, val};
    wrapSetWr = wr || val[0] === 1'bx;
    readParamWr = !wr;
    @(posedge clk);
    #1;
    wrapSetWr = 1'b0;
    readParamWr = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check(32'({ioOeN, memReqValid, contModeActive, frameActive, memRdReady}), 32'hf1);
    $display("reset test done");
  endtask
  task automatic test_quad_out();
    sawFull = 1'b0;
    xfer(`MFRE_OP_QUAD_OUT, 8, 1, 24'h0012fe, 8'h00, 8, 4, got);
    check(got, exp4(24'h0012fe));
    check(32'(sawFull), 32'h1);
    quadReadPermit = 1'b0;
    drove = 1'b0;
    xfer(`MFRE_OP_QUAD_OUT, 8, 1, 24'h000040, 8'h00, 8, 4, got);
    check(32'(drove), 32'h0);
    xfer(`MFRE_OP_QUAD_IO, 8, 4, 24'h000040, 8'h00, 4, 4, got);
    check(32'(drove), 32'h0);
    quadReadPermit = 1'b1;
    $display("quad output test done");
  endtask
  task automatic test_dual();
    xfer(`MFRE_OP_DUAL_IO, 8, 2, 24'h00a0f0, 8'ha5, 0, 2, got);
    check(got, exp4(24'h00a0f0));
    check(32'(contModeActive), 32'h1);
    xfer(8'h00, 0, 2, 24'h000310, 8'h3c, 0, 2, got);
    check(got, exp4(24'h000310));
    check(32'(contModeActive), 32'h0);
    xfer(`MFRE_OP_DUAL_IO, 8, 2, 24'h000520, 8'h00, 0, 2, got);
    check(got, exp4(24'h000520));
    $display("dual test done");
  endtask
  task automatic test_quad_io();
    logic [31:0] d;
    xfer(`MFRE_OP_QUAD_IO, 8, 4, 24'h00beef, 8'ha0, 4, 4, got);
    check(got, exp4(24'h00beef));
    xfer(8'h00, 0, 4, 24'h000777, 8'haf, 4, 4, got);
    check(got, exp4(24'h000777));
    host.start();
    host.clocks(4, 4, 1'b1, 32'hffff, d);
    host.stop();
    check(32'(contModeActive), 32'h0);
    xfer(`MFRE_OP_QUAD_IO, 8, 4, 24'h000900, 8'h00, 4, 4, got);
    check(got, exp4(24'h000900));
    $display("quad io test done");
  endtask
  task automatic test_wrap();
    int size;
    for (int l = 0; l < 4; l++) begin
      size = 8 << l;
      strobe_cfg(1'b1, 2'(l));
      xfer(`MFRE_OP_QUAD_IO, 8, 4, 24'h000200 + 24'(size - 2), 8'h00, 4, 4, got);
      check(got, {8'(size - 2), 8'(size - 1), 8'h00, 8'h01});
    end
    $display("wrap test done");
  endtask
  task automatic test_four_wire();
    logic [31:0] d;
    fourWireCmdMode = 1'b1;
    for (int p = 0; p < 3; p++) begin
      strobe_cfg(1'b0, 2'(p));
      xfer(`MFRE_OP_QUAD_IO, 2, 4, 24'h00033e, 8'h00, 2 * p, 4, got);
      check(got, exp4(24'h00033e));
    end
    host.start();
    host.clocks(2, 4, 1'b1, 32'(`MFRE_OP_RESET), d);
    host.stop();
    xfer(`MFRE_OP_QUAD_IO, 2, 4, 24'h000406, 8'ha3, 0, 4, got);
    check(got, exp4(24'h000406));
    check(32'(contModeActive), 32'h1);
    xfer(8'h00, 0, 4, 24'h000480, 8'h00, 0, 4, got);
    check(got, exp4(24'h000480));
    check(32'(contModeActive), 32'h0);
    fourWireCmdMode = 1'b0;
    $display("four-wire test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    test_reset();
    test_quad_out();
    test_dual();
    test_quad_io();
    test_wrap();
    test_four_wire();
    give_verdict();
  end
endmodule
